// ===== hw/clk_synth_pkg.sv
// Package: register map, field layout, reset values and timing of the clock synthesis unit
package clk_synth_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int          AW         = 3;
  localparam int          DW         = 16;
  localparam logic [2:0]  ADDR_CTRL  = 3'h0;
  localparam logic [2:0]  ADDR_DIVBY = 3'h1;
  localparam logic [2:0]  ADDR_STAT  = 3'h2;
  localparam logic [2:0]  ADDR_SHUT  = 3'h3;
  localparam logic [2:0]  ADDR_OCTRL = 3'h4;
  localparam logic [2:0]  ADDR_OPT1  = 3'h5;
  localparam logic [2:0]  ADDR_MASK  = 3'h6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_REF_SEL   = 0;
  localparam int CTRL_USE_PLL   = 1;
  localparam int CTRL_PLL_PD    = 2;
  localparam int SHUT_EN        = 0;
  localparam int POST_LSB       = 0;
  localparam int POST_W         = 3;
  localparam int TRIM_LSB       = 0;
  localparam int TRIM_W         = 10;
  localparam int OCTRL_RELAX_PD = 10;
  localparam int OCTRL_STBY     = 11;
  localparam int OCTRL_XTAL_PD  = 12;
  localparam int EV_W           = 3;
  localparam int EV_LOCK_GAIN   = 0;
  localparam int EV_LOCK_LOST   = 1;
  localparam int EV_REF_LOST    = 2;
  localparam int ST_LOCKED      = 3;
  localparam int ST_SHUT        = 4;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [DW-1:0]     CTRL_RST   = 16'h0004;
  localparam logic [POST_W-1:0] POST_RST   = 3'h0;
  localparam logic [POST_W-1:0] POST_MAX   = 3'h5;
  localparam logic [TRIM_W-1:0] TRIM_RST   = 10'h000;
  localparam logic [EV_W-1:0]   MASK_RST   = 3'h0;
  localparam logic [5:0]        DIV_ONE    = 6'h01;
  localparam logic [3:0]        PLL_MULT   = 4'h8;
  localparam int                OUT_MAX_MHZ = 32;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int REF_LOSS_NS   = 2000;
  localparam int REF_LOSS_CYC  = (REF_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : clk_synth_pkg

// ===== hw/clock_synthesis_unit.sv
// Clock synthesis unit: reference select, PLL/postscaler control, loss shutdown, trim
//
// Function
// [RL1] Software picks output clock from relaxation, crystal or external reference, up to 32MHz.
// [RL2] Without PLL the double-rate clock equals the selected reference.
// [RL3] With PLL the double-rate clock is reference times eight over the postscaler.
// [RL4] A three-bit postscaler field selects the divisor on the PLL output.
// [RL5] Codes zero to five give divisors 1 to 32; codes six, seven reserved.
// [RL6] Double-rate clock goes to the system integration unit.
// [RL7] System integration unit halves the double-rate clock for fifty percent duty.
// [RL8] Triple-rate clock goes to PWM and timer units.
// [RL9] Losing the PLL reference clock triggers a safety shutdown.
// [RL10] Software powers down relaxation and crystal oscillators independently.
// [RL11] Relaxation oscillator has a standby state apart from power-down.
// [RL12] Software can power down the PLL.
// [RL13] After reset relaxation oscillator is the reference, select bit cleared.
// [RL14] Software may switch to external reference, then power down relaxation oscillator.
// [RL15] Software switches to external only once that source is enabled and stable.
// [RL16] Ten-bit signed trim in oscillator control bits 0-9 tunes capacitance.
// [RL17] Each trim step moves relaxation frequency about 0.078% of 8MHz.
// [RL18] Reset loads the factory trim into flash option register one.
// [RL19] Boot software copies flash option register one into the trim field.
`timescale 1ns/10ps
module clock_synthesis_unit #(
  parameter int REF_LOSS_CYC = clk_synth_pkg::REF_LOSS_CYC
) (
  input  wire logic                                 clk_i,
  input  wire logic                                 rst_n_i,
  input  wire logic [clk_synth_pkg::AW-1:0]         addr_i,
  input  wire logic [clk_synth_pkg::DW-1:0]         wr_data_i,
  input  wire logic                                 wr_i,
  input  wire logic                                 rd_i,
  output logic      [clk_synth_pkg::DW-1:0]         rd_data_o,
  output logic                                      irq_o,
  input  wire logic                                 pll_lock_i,
  input  wire logic                                 ref_clk_i,
  input  wire logic [clk_synth_pkg::TRIM_W-1:0]     flash_trim_i,
  output logic                                      reference_source_select_o,
  output logic                                      pll_pd_o,
  output logic                                      pll_path_o,
  output logic      [clk_synth_pkg::POST_W-1:0]     post_code_o,
  output logic      [5:0]                           post_div_o,
  output logic                                      clk2x_en_o,
  output logic                                      clk3x_en_o,
  output logic                                      relax_pd_o,
  output logic                                      relax_stby_o,
  output logic                                      xtal_pd_o,
  output logic      [clk_synth_pkg::TRIM_W-1:0]     trim_o
);

  localparam int CW = $clog2(REF_LOSS_CYC + 1);
  localparam logic [CW-1:0] LOSS_LAST = CW'(REF_LOSS_CYC);
  localparam logic [CW-1:0] CNT_ONE   = CW'(1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                                  ref_sel;
    logic                                  use_pll;
    logic                                  pll_pd;
    logic                                  shut_en;
    logic [clk_synth_pkg::POST_W-1:0]      post_code;
    logic [clk_synth_pkg::TRIM_W-1:0]      trim;
    logic                                  relax_pd;
    logic                                  stby;
    logic                                  xtal_pd;
    logic [clk_synth_pkg::TRIM_W-1:0]      opt1;
    logic                                  opt_loaded;
    logic [clk_synth_pkg::EV_W-1:0]        stat;
    logic [clk_synth_pkg::EV_W-1:0]        mask;
    logic                                  shut;
    logic                                  lock_s1;
    logic                                  lock_s2;
    logic                                  lock_q;
    logic                                  ref_s1;
    logic                                  ref_s2;
    logic                                  ref_q;
    logic [CW-1:0]                         loss_cnt;
    logic [clk_synth_pkg::DW-1:0]          rd_data;
    logic                                  irq;
    logic                                  ref_sel_out;
    logic                                  pll_pd_out;
    logic                                  pll_path;
    logic [5:0]                            post_div;
    logic                                  en2x;
    logic                                  en3x;
    logic                                  relax_pd_out;
    logic                                  stby_out;
  } state_t;

  state_t s;
  state_t next_s;

  logic                              locked;
  logic                              ref_edge;
  logic                              watch;
  logic [clk_synth_pkg::EV_W-1:0]    ev;
  logic [clk_synth_pkg::EV_W-1:0]    w1c;
  logic [clk_synth_pkg::DW-1:0]      rmux;
  logic                              wr_ctrl;
  logic                              wr_divby;
  logic                              wr_stat;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;

    // Pin inputs: two flip-flops, then the edge/level stage
    next_s.lock_s1 = pll_lock_i;
    next_s.lock_s2 = s.lock_s1;
    next_s.ref_s1  = ref_clk_i;
    next_s.ref_s2  = s.ref_s1;
    next_s.ref_q   = s.ref_s2;
    next_s.lock_q  = s.lock_s2;
    locked         = s.lock_s2;
    ref_edge       = s.ref_s2 ^ s.ref_q;

    ev = '0;
    ev[clk_synth_pkg::EV_LOCK_GAIN] = locked & ~s.lock_q;
    ev[clk_synth_pkg::EV_LOCK_LOST] = ~locked & s.lock_q;

    // Reference watchdog runs whenever the PLL is powered, whether or not the PLL path is in use
    watch = ~s.pll_pd_out;
    if (!watch || ref_edge) begin
      next_s.loss_cnt = '0; // RL9
    end else if (s.loss_cnt != LOSS_LAST) begin
      next_s.loss_cnt = s.loss_cnt + CNT_ONE;
    end
    ev[clk_synth_pkg::EV_REF_LOST] = watch & ~ref_edge & (s.loss_cnt == LOSS_LAST - CNT_ONE); // RL9

    // Factory trim is captured once, on the first edge after reset release
    if (!s.opt_loaded) begin
      next_s.opt1       = flash_trim_i; // RL18
      next_s.opt_loaded = 1'b1;
    end

    wr_ctrl  = wr_i && (addr_i == clk_synth_pkg::ADDR_CTRL);
    wr_divby = wr_i && (addr_i == clk_synth_pkg::ADDR_DIVBY);
    wr_stat  = wr_i && (addr_i == clk_synth_pkg::ADDR_STAT);
    w1c      = wr_stat ? wr_data_i[clk_synth_pkg::EV_W-1:0] : '0;

    if (wr_ctrl) begin
      next_s.ref_sel = wr_data_i[clk_synth_pkg::CTRL_REF_SEL]; // RL14
      next_s.use_pll = wr_data_i[clk_synth_pkg::CTRL_USE_PLL];
      next_s.pll_pd  = wr_data_i[clk_synth_pkg::CTRL_PLL_PD]; // RL12
    end

    // Reserved postscaler codes are dropped so the divider never sees them
    if (wr_divby && wr_data_i[clk_synth_pkg::POST_LSB +: clk_synth_pkg::POST_W] <= clk_synth_pkg::POST_MAX) begin
      next_s.post_code = wr_data_i[clk_synth_pkg::POST_LSB +: clk_synth_pkg::POST_W]; // RL4 RL5
    end

    if (wr_i && addr_i == clk_synth_pkg::ADDR_SHUT) begin
      next_s.shut_en = wr_data_i[clk_synth_pkg::SHUT_EN];
    end

    if (wr_i && addr_i == clk_synth_pkg::ADDR_OCTRL) begin
      next_s.trim     = wr_data_i[clk_synth_pkg::TRIM_LSB +: clk_synth_pkg::TRIM_W]; // RL16 RL17
      next_s.relax_pd = wr_data_i[clk_synth_pkg::OCTRL_RELAX_PD]; // RL10
      next_s.stby     = wr_data_i[clk_synth_pkg::OCTRL_STBY]; // RL11
      next_s.xtal_pd  = wr_data_i[clk_synth_pkg::OCTRL_XTAL_PD]; // RL10
    end

    if (wr_i && addr_i == clk_synth_pkg::ADDR_MASK) begin
      next_s.mask = wr_data_i[clk_synth_pkg::EV_W-1:0];
    end

    // Sticky events: a set in the clearing cycle wins
    next_s.stat = (s.stat & ~w1c) | ev;

    // Shutdown holds until software acknowledges the loss
    if (ev[clk_synth_pkg::EV_REF_LOST] && s.shut_en) begin
      next_s.shut = 1'b1; // RL9
    end else if (w1c[clk_synth_pkg::EV_REF_LOST]) begin
      next_s.shut = 1'b0;
    end

    // New mask and new status both count, so the line never lags a mask write
    next_s.irq = |(next_s.stat & next_s.mask);

    // Effective controls; shutdown falls back to the relaxation oscillator
    next_s.ref_sel_out  = next_s.ref_sel & ~next_s.shut; // RL13 RL9
    next_s.pll_pd_out   = next_s.pll_pd | next_s.shut; // RL12 RL9
    // The running reference is never powered down under the clock
    next_s.relax_pd_out = next_s.relax_pd & next_s.ref_sel_out; // RL14 RL10
    next_s.stby_out     = next_s.stby & ~next_s.relax_pd_out & next_s.ref_sel_out; // RL11
    // PLL path only once locked; otherwise the reference passes straight
    next_s.pll_path     = next_s.use_pll & ~next_s.pll_pd_out & locked; // RL2 RL3 RL1
    next_s.post_div     = next_s.pll_path ? (clk_synth_pkg::DIV_ONE << next_s.post_code)
                                          : clk_synth_pkg::DIV_ONE; // RL3 RL5
    next_s.en2x         = 1'b1; // RL6
    // Triple-rate clock is tapped from the PLL, so it needs the PLL path
    next_s.en3x         = next_s.pll_path; // RL8

    rmux = '0;
    unique case (addr_i)
      clk_synth_pkg::ADDR_CTRL: begin
        rmux[clk_synth_pkg::CTRL_REF_SEL] = s.ref_sel;
        rmux[clk_synth_pkg::CTRL_USE_PLL] = s.use_pll;
        rmux[clk_synth_pkg::CTRL_PLL_PD]  = s.pll_pd;
      end
      clk_synth_pkg::ADDR_DIVBY: begin
        rmux[clk_synth_pkg::POST_LSB +: clk_synth_pkg::POST_W] = s.post_code;
      end
      clk_synth_pkg::ADDR_STAT: begin
        rmux[clk_synth_pkg::EV_W-1:0]    = s.stat;
        rmux[clk_synth_pkg::ST_LOCKED]   = locked;
        rmux[clk_synth_pkg::ST_SHUT]     = s.shut;
      end
      clk_synth_pkg::ADDR_SHUT: begin
        rmux[clk_synth_pkg::SHUT_EN] = s.shut_en;
      end
      clk_synth_pkg::ADDR_OCTRL: begin
        rmux[clk_synth_pkg::TRIM_LSB +: clk_synth_pkg::TRIM_W] = s.trim;
        rmux[clk_synth_pkg::OCTRL_RELAX_PD] = s.relax_pd;
        rmux[clk_synth_pkg::OCTRL_STBY]     = s.stby;
        rmux[clk_synth_pkg::OCTRL_XTAL_PD]  = s.xtal_pd;
      end
      clk_synth_pkg::ADDR_OPT1: begin
        rmux[clk_synth_pkg::TRIM_LSB +: clk_synth_pkg::TRIM_W] = s.opt1; // RL19
      end
      clk_synth_pkg::ADDR_MASK: begin
        rmux[clk_synth_pkg::EV_W-1:0] = s.mask;
      end
      default: begin
        rmux = '0;
      end
    endcase
    next_s.rd_data = rd_i ? rmux : '0;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s              <= '0;
      s.ref_sel      <= clk_synth_pkg::CTRL_RST[clk_synth_pkg::CTRL_REF_SEL]; // RL13
      s.use_pll      <= clk_synth_pkg::CTRL_RST[clk_synth_pkg::CTRL_USE_PLL];
      s.pll_pd       <= clk_synth_pkg::CTRL_RST[clk_synth_pkg::CTRL_PLL_PD];
      s.pll_pd_out   <= clk_synth_pkg::CTRL_RST[clk_synth_pkg::CTRL_PLL_PD];
      s.post_code    <= clk_synth_pkg::POST_RST;
      s.trim         <= clk_synth_pkg::TRIM_RST;
      s.mask         <= clk_synth_pkg::MASK_RST;
      s.post_div     <= clk_synth_pkg::DIV_ONE;
      s.en2x         <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data_o                 = s.rd_data;
  assign irq_o                     = s.irq;
  assign reference_source_select_o = s.ref_sel_out;
  assign pll_pd_o                  = s.pll_pd_out;
  assign pll_path_o                = s.pll_path;
  assign post_code_o               = s.post_code;
  assign post_div_o                = s.post_div;
  assign clk2x_en_o                = s.en2x;
  assign clk3x_en_o                = s.en3x;
  assign relax_pd_o                = s.relax_pd_out;
  assign relax_stby_o              = s.stby_out;
  assign xtal_pd_o                 = s.xtal_pd;
  assign trim_o                    = s.trim;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  post_reserved_a: assert property ( // RL5
    wr_divby && wr_data_i[2:0] > clk_synth_pkg::POST_MAX |=> $stable(post_code_o))
    else $error("reserved postscaler code accepted");

  post_range_a: assert property ( // RL4
    post_code_o <= clk_synth_pkg::POST_MAX)
    else $error("postscaler code out of range");

  bypass_div_a: assert property ( // RL2
    !pll_path_o |-> post_div_o == clk_synth_pkg::DIV_ONE)
    else $error("divider active without PLL");

  pll_div_a: assert property ( // RL3
    pll_path_o |-> post_div_o == (clk_synth_pkg::DIV_ONE << post_code_o))
    else $error("PLL divisor does not match code");

  triple_rate_a: assert property ( // RL8
    clk3x_en_o == pll_path_o)
    else $error("triple-rate enable disagrees with PLL path");

  loss_shut_a: assert property ( // RL9
    ev[2] && s.shut_en |=> pll_pd_o && !reference_source_select_o && !pll_path_o)
    else $error("reference loss did not shut down");

  loss_time_a: assert property ( // RL9
    !pll_pd_o && !ref_edge ##1 !pll_pd_o && !ref_edge [*8] |-> s.loss_cnt >= CW'(8) || s.loss_cnt == LOSS_LAST)
    else $error("loss watchdog not counting");

  pll_off_a: assert property ( // RL12
    wr_ctrl && wr_data_i[clk_synth_pkg::CTRL_PLL_PD] |=> pll_pd_o && !pll_path_o)
    else $error("PLL not powered down");

  relax_safe_a: assert property ( // RL14
    relax_pd_o |-> reference_source_select_o)
    else $error("running reference powered down");

  stby_apart_a: assert property ( // RL11
    !(relax_stby_o && relax_pd_o))
    else $error("standby and power-down together");

  sticky_set_a: assert property ( // RL9
    ev[2] |=> s.stat[clk_synth_pkg::EV_REF_LOST])
    else $error("loss flag not set");

  rd_one_a: assert property (
    !rd_i |=> rd_data_o == '0)
    else $error("read data outside its cycle");

  // ----------------------------------------------------------------
  // Register write, shutdown and interrupt checks
  // ----------------------------------------------------------------
  sticky_hold_a: assert property ( // RL9
    s.stat[clk_synth_pkg::EV_REF_LOST] && !w1c[clk_synth_pkg::EV_REF_LOST] |=> s.stat[clk_synth_pkg::EV_REF_LOST])
    else $error("loss flag dropped without clear");

  shut_hold_a: assert property ( // RL9
    s.shut && !w1c[clk_synth_pkg::EV_REF_LOST] |=> s.shut)
    else $error("shutdown left without clear");

  shut_force_a: assert property ( // RL9
    s.shut |-> pll_pd_o && !reference_source_select_o && !pll_path_o)
    else $error("shutdown not applied to outputs");

  ref_clear_a: assert property ( // RL13
    wr_ctrl && !wr_data_i[clk_synth_pkg::CTRL_REF_SEL] |=> !reference_source_select_o)
    else $error("relaxation reference not selected");

  trim_wr_a: assert property ( // RL16
    wr_i && addr_i == clk_synth_pkg::ADDR_OCTRL |=> trim_o == 10'($past(wr_data_i)))
    else $error("trim write not applied");

  xtal_wr_a: assert property ( // RL10
    wr_i && addr_i == clk_synth_pkg::ADDR_OCTRL && wr_data_i[clk_synth_pkg::OCTRL_XTAL_PD] |=> xtal_pd_o)
    else $error("crystal power-down not applied");

  opt_load_a: assert property ( // RL18
    $rose(s.opt_loaded) |-> s.opt1 == $past(flash_trim_i))
    else $error("factory trim not captured");

  stby_ref_a: assert property ( // RL11
    relax_stby_o |-> reference_source_select_o)
    else $error("running reference put in standby");

  path_pwr_a: assert property ( // RL12
    pll_path_o |-> !pll_pd_o)
    else $error("PLL path used while powered down");

  post_hold_a: assert property ( // RL4
    !wr_divby |=> $stable(post_code_o))
    else $error("postscaler changed without write");

  clk2x_on_a: assert property ( // RL6
    clk2x_en_o)
    else $error("double-rate clock disabled");

  irq_level_a: assert property (
    irq_o == |(s.stat & s.mask))
    else $error("interrupt disagrees with status and mask");

endmodule : clock_synthesis_unit

// ===== test/pll_far_model.sv
// Behavioural far side: PLL lock source, reference clock source and system clock halver
`timescale 1ns/10ps
module pll_far_model #(
  parameter int LOCK_CYC = 10,
  parameter int HALF_CYC = 3
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pll_pd_i,
  input  wire logic ref_run_i,
  input  wire logic clk2x_en_i,
  output logic      pll_lock_o,
  output logic      ref_clk_o,
  output logic      sys_clk_o
);
  int lock_cnt;
  int half_cnt;

  // ----------------------------------------------------------------
  // Lock and reference
  // ----------------------------------------------------------------
  // No lock without power or reference; a stopped reference stands still
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_cnt   <= 0;
      half_cnt   <= 0;
      pll_lock_o <= 1'b0;
      ref_clk_o  <= 1'b0;
      sys_clk_o  <= 1'b0;
    end else begin
      if (pll_pd_i || !ref_run_i) begin
        lock_cnt   <= 0;
        pll_lock_o <= 1'b0;
      end else if (lock_cnt < LOCK_CYC) begin
        lock_cnt <= lock_cnt + 1;
      end else begin
        pll_lock_o <= 1'b1;
      end
      if (ref_run_i) begin
        half_cnt <= (half_cnt == HALF_CYC - 1) ? 0 : half_cnt + 1;
        if (half_cnt == HALF_CYC - 1) begin
          ref_clk_o <= ~ref_clk_o;
        end
      end
      if (clk2x_en_i) begin
        sys_clk_o <= ~sys_clk_o;
      end
    end
  end
endmodule : pll_far_model

// ===== test/on_chip_clock_synthesis_test.sv
// Self-checking testbench of the clock synthesis unit
`timescale 1ns/10ps
module on_chip_clock_synthesis_test;
  localparam int LOSS = 16;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [15:0] wr_data = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [9:0]  flash_trim;
  logic        ref_run = 1'b1;
  logic [15:0] rd_data;
  logic        irq, lock, ref_clk, ref_sel, pll_pd, pll_path, clk2x, clk3x;
  logic        relax_pd, relax_stby, xtal_pd, rd_q = 1'b0;
  logic        sys_clk, sc;
  logic [2:0]  post_code;
  logic [5:0]  post_div;
  logic [9:0]  trim, t;
  logic [15:0] exp_q[$];
  logic [2:0]  last;
  int          num_errors = 0;
  int          n_compared = 0;

  clock_synthesis_unit #(.REF_LOSS_CYC(LOSS)) DUT (
    .clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wr_data_i(wr_data), .wr_i(wr), .rd_i(rd),
    .rd_data_o(rd_data), .irq_o(irq), .pll_lock_i(lock), .ref_clk_i(ref_clk), .flash_trim_i(flash_trim),
    .reference_source_select_o(ref_sel), .pll_pd_o(pll_pd), .pll_path_o(pll_path),
    .post_code_o(post_code), .post_div_o(post_div), .clk2x_en_o(clk2x), .clk3x_en_o(clk3x),
    .relax_pd_o(relax_pd), .relax_stby_o(relax_stby), .xtal_pd_o(xtal_pd), .trim_o(trim));

  pll_far_model far (
    .clk_i(clk), .rst_n_i(rst_n), .pll_pd_i(pll_pd), .ref_run_i(ref_run), .clk2x_en_i(clk2x),
    .pll_lock_o(lock), .ref_clk_o(ref_clk), .sys_clk_o(sys_clk));

  initial begin
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr      <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : bus_read

  // Outputs are registered on the last edge of a write; three spare edges keep clear of it
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask : settle

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  // Read data stand only in the cycle after the strobe and are zero otherwise
  always @(posedge clk) begin
    if (rst_n) begin
      if (rd_q) begin
        check(rd_data, exp_q.pop_front());
      end else begin
        check(rd_data, 16'h0000);
      end
    end
    rd_q <= rd;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h6f3e));
    flash_trim <= 10'($urandom);
    repeat (20) @(posedge clk);
    check({ref_sel, pll_pd, post_div, clk2x}, {1'b0, 1'b1, 6'h01, 1'b1});
    rst_n <= 1'b1;
    bus_read(clk_synth_pkg::ADDR_CTRL, 16'h0004);
    bus_read(clk_synth_pkg::ADDR_MASK, 16'h0000);
    bus_read(clk_synth_pkg::ADDR_OPT1, {6'h00, flash_trim});
    // Boot sequence copies the factory trim, then random trims follow
    bus_write(clk_synth_pkg::ADDR_OCTRL, {6'h00, flash_trim});
    settle();
    check(trim, flash_trim);
    for (int i = 0; i < 4; i++) begin
      t = 10'($urandom);
      bus_write(clk_synth_pkg::ADDR_OCTRL, {6'h00, t});
      bus_read(clk_synth_pkg::ADDR_OCTRL, {6'h00, t});
      settle();
      check(trim, t);
    end
    // PLL up with events masked, then unmasked and cleared
    bus_write(clk_synth_pkg::ADDR_CTRL, 16'h0002);
    repeat (30) @(posedge clk);
    check(irq, 1'b0);
    bus_read(clk_synth_pkg::ADDR_STAT, 16'h0009);
    bus_write(clk_synth_pkg::ADDR_MASK, 16'h0007);
    settle();
    check(irq, 1'b1);
    bus_write(clk_synth_pkg::ADDR_STAT, 16'h0007);
    settle();
    check(irq, 1'b0);
    bus_read(clk_synth_pkg::ADDR_STAT, 16'h0008);
    check({pll_pd, pll_path, clk2x, clk3x}, 4'b0111);
    // Every postscaler code, the reserved ones must leave the last legal code
    last = 3'h0;
    for (int c = 0; c < 8; c++) begin
      bus_write(clk_synth_pkg::ADDR_DIVBY, 16'(c));
      if (c <= 5) begin
        last = 3'(c);
      end
      settle();
      check(post_code, last);
      check(post_div, 6'h01 << last);
      bus_read(clk_synth_pkg::ADDR_DIVBY, {13'h0000, last});
    end
    bus_write(clk_synth_pkg::ADDR_CTRL, 16'h0000);
    settle();
    check({pll_path, clk3x, post_div, clk2x}, {2'b00, 6'h01, 1'b1});
    bus_write(clk_synth_pkg::ADDR_CTRL, 16'h0004);
    settle();
    check(pll_pd, 1'b1);
    // Relaxation power-down is refused while it is the reference
    bus_write(clk_synth_pkg::ADDR_OCTRL, {6'h01, t});
    settle();
    check(relax_pd, 1'b0);
    bus_write(clk_synth_pkg::ADDR_CTRL, 16'h0005);
    settle();
    check({ref_sel, relax_pd, relax_stby, xtal_pd}, 4'b1100);
    bus_write(clk_synth_pkg::ADDR_OCTRL, {6'h02, t});
    settle();
    check({relax_pd, relax_stby, xtal_pd}, 3'b010);
    bus_write(clk_synth_pkg::ADDR_OCTRL, {6'h04, t});
    settle();
    check({relax_pd, relax_stby, xtal_pd, trim}, {3'b001, t});
    // Reference loss with shutdown enabled
    bus_write(clk_synth_pkg::ADDR_SHUT, 16'h0001);
    bus_write(clk_synth_pkg::ADDR_CTRL, 16'h0003);
    repeat (30) @(posedge clk);
    bus_write(clk_synth_pkg::ADDR_STAT, 16'h0007);
    settle();
    check({pll_path, clk3x, irq}, 3'b110);
    ref_run <= 1'b0;
    for (int i = 0; i < LOSS + 20 && pll_pd !== 1'b1; i++) begin
      @(posedge clk);
    end
    settle();
    check({pll_pd, ref_sel, pll_path, irq}, 4'b1001);
    bus_read(clk_synth_pkg::ADDR_STAT, 16'h0016);
    ref_run <= 1'b1;
    bus_write(clk_synth_pkg::ADDR_STAT, 16'h0007);
    settle();
    check({pll_pd, ref_sel}, 2'b01);
    bus_read(3'h7, 16'h0000);
    bus_write(3'h7, 16'hFFFF);
    bus_read(clk_synth_pkg::ADDR_CTRL, 16'h0003);
    settle();
    sc = sys_clk;
    @(posedge clk);
    check(sys_clk ^ sc, 1'b1);
    complete_run();
  end
endmodule : on_chip_clock_synthesis_test
